// ===== hw/adcs_sequencer.sv
// Conversion sequencer: command queue, modes, trigger, delay, result buffer
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps

module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int DEPTH = ADCS_DEPTH,
    parameter int DLY_W = ADCS_DLY_W,
    parameter int TSRC  = ADCS_TSRC
) (
    // Clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    // APB slave
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [7:0]         i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    // Hardware trigger sources, one-cycle event pulses
    input  wire logic [TSRC-1:0]    i_hw_trigger,
    // Converter macro
    output adcs_cmd_type            o_conv,
    input  wire adcs_res_type       i_conv
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [7:0] RES_SPAN = 8'(DEPTH * 8);

    typedef struct packed {
        adcs_fsm_type               fsm;
        adcs_mode_type              prev_mode;
        logic                       circular;
        logic                       left_align;
        logic                       reload_en;
        logic                       autoflush_enable_en;
        logic                       mcflush_en;
        logic                       hwtrg_en;
        logic                       arm;
        logic [3:0]                 trig_sel;
        logic [DLY_W-1:0]           dly_cfg;
        logic [DLY_W-1:0]           dly_cnt;
        logic [PTR_W-1:0]           wptr;
        logic [PTR_W-1:0]           rptr;
        logic [CNT_W-1:0]           count;
        logic [DEPTH-1:0][3:0]      queue;
        logic [DEPTH-1:0][7:0]      res_hi;
        logic [DEPTH-1:0][7:0]      res_lo;
        logic                       conv_done;
        logic                       seq_done;
        logic                       full_evt;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        adcs_cmd_type               conv;
    } adcs_regs_type;

    adcs_regs_type state_reg;
    adcs_regs_type state_next;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    function automatic adcs_mode_type mode_of(input logic circ,
                                              input logic rel,
                                              input logic af);
        if (circ) begin
            mode_of = rel ? ADCS_RELOAD : ADCS_CONT;
        end else begin
            mode_of = af ? ADCS_SINGLE_AF : ADCS_SINGLE;
        end
    endfunction : mode_of

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        adcs_mode_type     mode;
        logic              acc;
        logic              wr;
        logic              hit;
        logic [31:0]       rdata;
        logic [7:0]        roff;
        logic [PTR_W-1:0]  ridx;
        logic              sw_start;
        logic              sw_stop;
        logic              flush;
        logic              push;
        logic              inc;
        logic              dec;
        logic              full_set;
        logic              start_req;
        logic              last;
        logic              repeat_mode;
        logic [9:0]        d;

        state_next = state_reg;
        mode        = mode_of(state_reg.circular, state_reg.reload_en,
                              state_reg.autoflush_enable_en);
        repeat_mode = state_reg.circular;
        acc         = i_psel & i_penable;
        wr          = acc & state_reg.pready & i_pwrite;
        roff        = i_paddr - ADCS_RES_BASE;
        ridx        = roff[ADCS_RES_IDX +: PTR_W];
        sw_start    = 1'b0;
        sw_stop     = 1'b0;
        flush       = 1'b0;
        push        = 1'b0;
        inc         = 1'b0;
        dec         = 1'b0;
        full_set    = 1'b0;
        last        = 1'b0;
        start_req   = 1'b0;
        d           = i_conv.data;
        state_next.conv.start = 1'b0;
        state_next.conv.abort = 1'b0;

        // APB decode and read mux; one wait state on every access
        hit   = 1'b1;
        rdata = ADCS_ZERO;
        unique case (i_paddr)
            ADCS_CFG_OFF: begin
                rdata[ADCS_CFG_CIRC] = state_reg.circular;
                rdata[ADCS_CFG_LEFT] = state_reg.left_align;
            end
            ADCS_START_OFF: rdata = ADCS_ZERO;
            ADCS_STAT_OFF: begin
                rdata[ADCS_ST_CONV] = state_reg.conv_done;
                rdata[ADCS_ST_SEQ]  = state_reg.seq_done;
                rdata[ADCS_ST_FULL] = state_reg.full_evt;
                rdata[ADCS_ST_BUSY] = state_reg.fsm != ADCS_IDLE;
                rdata[ADCS_ST_WPTR +: PTR_W] = state_reg.wptr;
                rdata[ADCS_ST_RPTR +: PTR_W] = state_reg.rptr;
            end
            ADCS_DLY_OFF: rdata[DLY_W-1:0] = state_reg.dly_cfg;
            ADCS_CMD_OFF: rdata = ADCS_ZERO;
            ADCS_OPT_OFF: begin
                rdata[ADCS_OPT_RELOAD] = state_reg.reload_en;
                rdata[ADCS_OPT_AUTOFLUSH_ENABLE] = state_reg.autoflush_enable_en;
                rdata[ADCS_OPT_MCFL]   = state_reg.mcflush_en;
                rdata[ADCS_OPT_HWTRG]  = state_reg.hwtrg_en;
            end
            ADCS_ARM_OFF: rdata[ADCS_ARM_BIT] = state_reg.arm;
            ADCS_TSEL_OFF: rdata[3:0] = state_reg.trig_sel;
            default: begin
                hit = (i_paddr >= ADCS_RES_BASE) && (roff < RES_SPAN)
                      && (i_paddr[1:0] == 2'b00);
                if (hit) begin
                    rdata[7:0] = roff[ADCS_RES_HI] ? state_reg.res_hi[ridx]
                                                   : state_reg.res_lo[ridx];
                end
            end
        endcase
        state_next.pready  = acc & ~state_reg.pready;
        state_next.pslverr = acc & ~state_reg.pready & ~hit;
        if (acc & ~state_reg.pready) begin
            state_next.prdata = i_pwrite ? ADCS_ZERO : rdata;
        end

        // Register writes take effect at the completing edge
        if (wr & hit) begin
            unique case (i_paddr)
                ADCS_CFG_OFF: begin
                    state_next.circular   = i_pwdata[ADCS_CFG_CIRC];
                    state_next.left_align = i_pwdata[ADCS_CFG_LEFT];
                    flush   = i_pwdata[ADCS_CFG_FLUSH];
                    sw_stop = i_pwdata[ADCS_CFG_STOP];
                end
                ADCS_START_OFF: sw_start = i_pwdata[ADCS_START_BIT];
                ADCS_STAT_OFF: begin
                    // Write one to clear
                    if (i_pwdata[ADCS_ST_CONV]) begin
                        state_next.conv_done = 1'b0;
                    end
                    if (i_pwdata[ADCS_ST_SEQ]) begin
                        state_next.seq_done = 1'b0;
                    end
                end
                ADCS_DLY_OFF: state_next.dly_cfg = i_pwdata[DLY_W-1:0];
                ADCS_CMD_OFF: push = 1'b1;
                ADCS_OPT_OFF: begin
                    state_next.reload_en  = i_pwdata[ADCS_OPT_RELOAD];
                    state_next.autoflush_enable_en  = i_pwdata[ADCS_OPT_AUTOFLUSH_ENABLE];
                    state_next.mcflush_en = i_pwdata[ADCS_OPT_MCFL];
                    state_next.hwtrg_en   = i_pwdata[ADCS_OPT_HWTRG];
                end
                ADCS_ARM_OFF: state_next.arm = i_pwdata[ADCS_ARM_BIT];
                ADCS_TSEL_OFF: state_next.trig_sel = i_pwdata[3:0];
                default: ;
            endcase
        end

        // Mode tracked one cycle behind; a change triggers the implicit flush
        state_next.prev_mode = mode;
        if (state_reg.mcflush_en && (mode != state_reg.prev_mode)) begin
            flush = 1'b1;
        end

        // Queue push; a write to a full queue only raises the event
        if (push) begin
            if (state_reg.count == FULL_CNT) begin
                full_set = 1'b1;
            end else begin
                state_next.queue[state_reg.wptr] = i_pwdata[3:0];
                state_next.wptr = state_reg.wptr + 1'b1;
                inc = 1'b1;
            end
        end

        // Either source may start; trigger only while armed and enabled
        start_req = sw_start | (state_reg.hwtrg_en & state_reg.arm
                    & i_hw_trigger[state_reg.trig_sel]);

        // ************************************************************
        // Sequencer
        // ************************************************************
        unique case (state_reg.fsm)
            ADCS_IDLE: begin
                // Empty queue cannot start; software must load it first
                if (start_req && (state_reg.count != '0)) begin
                    state_next.arm     = 1'b0;
                    state_next.dly_cnt = state_reg.dly_cfg;
                    if (repeat_mode) begin
                        state_next.rptr = '0;
                    end
                    state_next.fsm = (state_reg.dly_cfg == '0) ? ADCS_ISSUE
                                                               : ADCS_WAIT_DLY;
                end
            end
            ADCS_WAIT_DLY: begin
                // Start requests are dropped while busy
                state_next.dly_cnt = state_reg.dly_cnt - 1'b1;
                if (state_reg.dly_cnt <= 1) begin
                    state_next.fsm = ADCS_ISSUE;
                end
            end
            ADCS_ISSUE: begin
                state_next.conv.start   = 1'b1;
                state_next.conv.gain    = state_reg.queue[state_reg.rptr][ADCS_CMD_GAIN];
                state_next.conv.channel = state_reg.queue[state_reg.rptr][2:0];
                state_next.fsm          = ADCS_CONV;
            end
            ADCS_CONV: begin
                if (i_conv.done) begin
                    if (state_reg.left_align) begin
                        state_next.res_hi[state_reg.rptr] = d[9:2];
                        state_next.res_lo[state_reg.rptr] = {d[1:0], 6'h00};
                    end else begin
                        state_next.res_hi[state_reg.rptr] = {6'h00, d[9:8]};
                        state_next.res_lo[state_reg.rptr] = d[7:0];
                    end
                    state_next.conv_done = 1'b1;
                    state_next.rptr = state_reg.rptr + 1'b1;
                    if (repeat_mode) begin
                        last = (CNT_W'(state_reg.rptr) + 1'b1) == state_reg.count;
                    end else begin
                        dec  = 1'b1;
                        last = (state_reg.count + inc) == CNT_W'(1);
                    end
                    state_next.fsm = ADCS_ISSUE;
                    if (last) begin
                        state_next.seq_done = 1'b1;
                        unique case (mode)
                            ADCS_CONT: begin
                                state_next.rptr = '0;
                            end
                            ADCS_RELOAD: begin
                                state_next.rptr = '0;
                                state_next.fsm  = ADCS_IDLE;
                            end
                            ADCS_SINGLE_AF: begin
                                flush          = 1'b1;
                                state_next.fsm = ADCS_IDLE;
                            end
                            ADCS_SINGLE: begin
                                // Pointers keep their place for the next run
                                state_next.fsm = ADCS_IDLE;
                            end
                        endcase
                    end
                end
            end
        endcase

        // Stop wins over the sequencer in the same cycle
        if (sw_stop) begin
            state_next.arm = 1'b0;
            state_next.fsm = ADCS_IDLE;
            state_next.conv.start = 1'b0;
            state_next.conv.abort = state_reg.fsm != ADCS_IDLE;
            dec = 1'b0;
        end

        // Count update; consuming an entry clears the full event
        state_next.count = state_reg.count + inc - dec;
        if (dec) begin
            state_next.full_evt = 1'b0;
        end
        if (flush) begin
            state_next.wptr     = '0;
            state_next.rptr     = '0;
            state_next.count    = '0;
            state_next.full_evt = 1'b0;
            if (push && !full_set) begin
                state_next.queue[0] = i_pwdata[3:0];
                state_next.wptr     = PTR_W'(1);
                state_next.count    = CNT_W'(1);
            end
        end
        // Setting the event wins over any clear in the same cycle
        if (full_set) begin
            state_next.full_evt = 1'b1;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg            <= '0;
            state_reg.fsm        <= ADCS_IDLE;
            state_reg.prev_mode  <= ADCS_SINGLE;
            state_reg.reload_en  <= ADCS_OPT_RST[ADCS_OPT_RELOAD];
            state_reg.autoflush_enable_en  <= ADCS_OPT_RST[ADCS_OPT_AUTOFLUSH_ENABLE];
            state_reg.mcflush_en <= ADCS_OPT_RST[ADCS_OPT_MCFL];
            state_reg.hwtrg_en   <= ADCS_OPT_RST[ADCS_OPT_HWTRG];
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_prdata  = state_reg.prdata;
    assign o_pready  = state_reg.pready;
    assign o_pslverr = state_reg.pslverr;
    assign o_conv    = state_reg.conv;

endmodule : adcs_sequencer

// ===== pkg/adcs_pkg.sv
// Shared constants and carrier types of the conversion sequencer
package adcs_pkg;

    // ****************************************************************
    // Register map (APB byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADCS_CFG_OFF   = 8'h00;
    localparam logic [7:0] ADCS_START_OFF = 8'h04;
    localparam logic [7:0] ADCS_STAT_OFF  = 8'h08;
    localparam logic [7:0] ADCS_DLY_OFF   = 8'h0C;
    localparam logic [7:0] ADCS_CMD_OFF   = 8'h10;
    localparam logic [7:0] ADCS_OPT_OFF   = 8'h14;
    localparam logic [7:0] ADCS_ARM_OFF   = 8'h18;
    localparam logic [7:0] ADCS_TSEL_OFF  = 8'h1C;
    localparam logic [7:0] ADCS_RES_BASE  = 8'h20;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ADCS_CFG_CIRC   = 0;
    localparam int ADCS_CFG_LEFT   = 1;
    localparam int ADCS_CFG_FLUSH  = 2;
    localparam int ADCS_CFG_STOP   = 3;
    localparam int ADCS_START_BIT  = 0;
    localparam int ADCS_ST_CONV    = 0;
    localparam int ADCS_ST_SEQ     = 1;
    localparam int ADCS_ST_FULL    = 2;
    localparam int ADCS_ST_BUSY    = 3;
    localparam int ADCS_ST_WPTR    = 8;
    localparam int ADCS_ST_RPTR    = 12;
    localparam int ADCS_OPT_RELOAD = 0;
    localparam int ADCS_OPT_AUTOFLUSH_ENABLE = 1;
    localparam int ADCS_OPT_MCFL   = 2;
    localparam int ADCS_OPT_HWTRG  = 3;
    localparam int ADCS_ARM_BIT    = 0;
    localparam int ADCS_CMD_GAIN   = 3;
    localparam int ADCS_RES_HI     = 2;
    localparam int ADCS_RES_IDX    = 3;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int          ADCS_DEPTH    = 8;
    localparam int          ADCS_DLY_W    = 8;
    localparam int          ADCS_TSRC     = 16;
    localparam logic [3:0]  ADCS_OPT_RST  = 4'h4;
    localparam logic [31:0] ADCS_ZERO     = 32'h0000_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_WAIT_DLY,
        ADCS_ISSUE,
        ADCS_CONV
    } adcs_fsm_type;

    typedef enum logic [1:0] {
        ADCS_SINGLE,
        ADCS_SINGLE_AF,
        ADCS_CONT,
        ADCS_RELOAD
    } adcs_mode_type;

    // Command toward the converter macro
    typedef struct packed {
        logic       start;
        logic       abort;
        logic       gain;
        logic [2:0] channel;
    } adcs_cmd_type;

    // Answer from the converter macro
    typedef struct packed {
        logic       done;
        logic [9:0] data;
    } adcs_res_type;

endpackage : adcs_pkg

// ===== bench/adcs_sequencer_sva.sv
// Port assertions for the conversion sequencer
`timescale 1ns/1ps
module adcs_chk
    import adcs_pkg::*;
(
    // Clock, reset and bus
    input wire logic         i_clock,
    input wire logic         i_rst_n,
    input wire logic         i_psel,
    input wire logic         i_penable,
    input wire logic         i_pwrite,
    input wire logic [7:0]   i_paddr,
    input wire logic [31:0]  i_pwdata,
    input wire logic [31:0]  o_prdata,
    input wire logic         o_pready,
    input wire logic         o_pslverr,
    // Converter side
    input wire adcs_cmd_type o_conv
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    property p_wait; i_psel && i_penable && !o_pready |=> o_pready; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; o_pslverr |-> o_pready && i_psel; endproperty
    a_err: assert property (p_err) else $error("stray slverr");
    property p_unmap; o_pready && i_psel && i_paddr >= 8'h60 |-> o_pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped accepted");
    property p_cmd0; o_pready && !i_pwrite && i_paddr == ADCS_CMD_OFF |-> o_prdata == ADCS_ZERO;
    endproperty
    a_cmd0: assert property (p_cmd0) else $error("command port readable");
    property p_hold; !o_conv.start |-> $stable({o_conv.gain, o_conv.channel}); endproperty
    a_hold: assert property (p_hold) else $error("command moved");
    property p_abort; o_conv.abort |-> $past(o_pready && i_pwrite && i_paddr == ADCS_CFG_OFF
        && i_pwdata[ADCS_CFG_STOP]); endproperty
    a_abort: assert property (p_abort) else $error("abort without stop");
    property p_stop; o_conv.abort |-> !o_conv.start ##1 !o_conv.start [*2]; endproperty
    a_stop: assert property (p_stop) else $error("start after stop");
endmodule : adcs_chk
bind adcs_sequencer adcs_chk i_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_conv(o_conv));

// ===== bench/adcs_conv_model.sv
// Behavioural converter macro facing the sequencer
`timescale 1ns/1ps
module adcs_conv_model
    import adcs_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    // Sequencer side, and the bench's slow-conversion select
    input  wire adcs_cmd_type i_cmd,
    input  wire logic         i_slow,
    output adcs_res_type      o_res
);
    logic       busy_reg;
    logic [5:0] cnt_reg;
    logic [3:0] cmd_reg;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_reg <= 1'h0;
            cnt_reg  <= 6'h0;
            cmd_reg  <= 4'h0;
            o_res    <= '0;
        end else begin
            o_res.done <= 1'h0;
            // Released data line toggles so stale data never matches
            o_res.data <= ~o_res.data;
            if (i_cmd.abort) begin
                busy_reg <= 1'h0;
            end else if (i_cmd.start) begin
                busy_reg <= 1'h1;
                cnt_reg  <= i_slow ? 6'h28 : 6'h4;
                cmd_reg  <= {i_cmd.gain, i_cmd.channel};
            end else if (busy_reg && cnt_reg == 6'h0) begin
                busy_reg   <= 1'h0;
                o_res.done <= 1'h1;
                o_res.data <= {cmd_reg, cmd_reg, 2'h2};
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 6'h1;
            end
        end
    end
endmodule : adcs_conv_model

// ===== bench/tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb;
    import adcs_pkg::*;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, pready, pslverr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd_data;
    logic [15:0] trig = 0;
    adcs_cmd_type conv;
    adcs_res_type res;
    int error_cnt, n_compared, n_starts, s, k;
    logic [3:0] cmds [8] = '{4'h3, 4'hC, 4'h7, 4'h8, 4'h1, 4'hE, 4'h5, 4'hA};
    always #4 clock = ~clock;
    always @(posedge clock) if (conv.start === 1'h1) n_starts++;
    adcs_sequencer i_dut (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_hw_trigger(trig), .o_conv(conv), .i_conv(res));
    adcs_conv_model i_mdl (.i_clock(clock), .i_rst_n(rst_n), .i_cmd(conv), .i_slow(slow),
        .o_res(res));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock) penable <= 1;
        // No cycle count is assumed; only the watchdog ends a hung wait
        do @(posedge clock); while (pready !== 1'h1);
        rd_data = pslverr === 1'h1 ? 32'hFFFF_FFFF : prdata;
        psel <= 0; penable <= 0;
        @(posedge clock);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 0); chk(rd_data & m, e);
    endtask : rd
    task automatic push(input int f, input int n);
        for (int i = f; i < f + n; i++) wr(ADCS_CMD_OFF, {28'h0, cmds[i % 8]});
    endtask : push
    task automatic wait_seq;
        int n;
        n = 0;
        do begin apb(0, ADCS_STAT_OFF, 0); n++; end while (rd_data[1] !== 1'h1 && n < 200);
        chk(rd_data & 32'h3, 32'h3);
        wr(ADCS_STAT_OFF, 32'h3);
    endtask : wait_seq
    task automatic result(input int i, input logic [3:0] c, input logic left);
        logic [9:0] d;
        d = {c, c, 2'h2};
        rd(ADCS_RES_BASE + 8'(8 * i), 32'hFF, left ? {24'h0, d[1:0], 6'h0} : {24'h0, d[7:0]});
        rd(ADCS_RES_BASE + 8'(8 * i + 4), 32'hFF, left ? {24'h0, d[9:2]} : {30'h0, d[9:8]});
    endtask : result
    task automatic pulse(input int b);
        trig <= 16'h1 << b;
        @(posedge clock) trig <= 16'h0;
    endtask : pulse
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // ****
    // Tests
    // ****
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        rd(ADCS_OPT_OFF, 32'hF, 32'h4);
        rd(8'h60, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        wr(ADCS_CMD_OFF, 32'h3);
        rd(ADCS_CMD_OFF, 32'hFFFF_FFFF, 32'h0);
        wr(ADCS_CFG_OFF, 32'h4);
        rd(ADCS_STAT_OFF, 32'h770F, 32'h0);
        wr(ADCS_START_OFF, 32'h1);
        rd(ADCS_STAT_OFF, 32'h8, 32'h0);
        push(0, 3);
        s = n_starts;
        wr(ADCS_START_OFF, 32'h1);
        wr(ADCS_START_OFF, 32'h1);
        wait_seq;
        chk(n_starts - s, 3);
        rd(ADCS_STAT_OFF, 32'h770F, 32'h3300);
        for (int i = 0; i < 3; i++) result(i, cmds[i], 0);
        wr(ADCS_CFG_OFF, 32'h2);
        push(3, 2);
        wr(ADCS_START_OFF, 32'h1);
        wait_seq;
        rd(ADCS_STAT_OFF, 32'h3, 32'h0);
        for (int i = 3; i < 5; i++) result(i, cmds[i], 1);
        $display("single mode done");
        push(0, 9);
        rd(ADCS_STAT_OFF, 32'h4, 32'h4);
        wr(ADCS_CFG_OFF, 32'h6);
        rd(ADCS_STAT_OFF, 32'h7704, 32'h0);
        wr(ADCS_DLY_OFF, 32'h3);
        push(0, 2);
        wr(ADCS_START_OFF, 32'h1);
        for (k = 0; conv.start !== 1'h1 && k < 20; k++) @(posedge clock);
        chk(k, 4);
        for (k = 0; res.done !== 1'h1 && k < 99; k++) @(posedge clock);
        // Done is taken at this edge; the next start stands one cycle later
        repeat (2) @(posedge clock);
        chk(conv.start, 1);
        wait_seq;
        wr(ADCS_OPT_OFF, 32'h6);
        rd(ADCS_STAT_OFF, 32'h7700, 32'h0);
        push(0, 2);
        wr(ADCS_START_OFF, 32'h1);
        wait_seq;
        rd(ADCS_STAT_OFF, 32'h7708, 32'h0);
        wr(ADCS_OPT_OFF, 32'hE);
        wr(ADCS_TSEL_OFF, 32'h5);
        push(0, 1);
        wr(ADCS_ARM_OFF, 32'h1);
        pulse(6);
        rd(ADCS_ARM_OFF, 32'h1, 32'h1);
        pulse(5);
        rd(ADCS_ARM_OFF, 32'h1, 32'h0);
        wait_seq;
        wr(ADCS_ARM_OFF, 32'h1);
        wr(ADCS_ARM_OFF, 32'h0);
        push(0, 1);
        pulse(5);
        rd(ADCS_STAT_OFF, 32'hB, 32'h0);
        $display("trigger done");
        wr(ADCS_OPT_OFF, 32'h4);
        wr(ADCS_CFG_OFF, 32'h1);
        push(0, 2);
        wr(ADCS_START_OFF, 32'h1);
        wait_seq;
        wait_seq;
        wr(ADCS_CFG_OFF, 32'h9);
        rd(ADCS_STAT_OFF, 32'h8, 32'h0);
        result(1, cmds[1], 0);
        wr(ADCS_OPT_OFF, 32'h5);
        push(2, 2);
        wr(ADCS_START_OFF, 32'h1);
        wait_seq;
        rd(ADCS_STAT_OFF, 32'h7708, 32'h0200);
        slow <= 1;
        wr(ADCS_START_OFF, 32'h1);
        wait_seq;
        result(1, cmds[3], 0);
        $display("repeat modes done");
        close_out();
    end
    initial begin
        #320000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
endmodule : tb
